// file: inc/dbsp_pkg.sv
// Shared constants and helpers for the burst-of-two DDR static memory port
`default_nettype none
package dbsp_pkg;
    // Supported organisations: wide 36-bit words or narrow 18-bit words
    localparam int DBSP_DATA_W_WIDE = 36;
    localparam int DBSP_DATA_W_NARROW = 18;
    // One address names a burst of two words, so 2M words need 20 bits, 4M words 21
    localparam int DBSP_ADDR_W_WIDE = 20;
    localparam int DBSP_ADDR_W_NARROW = 21;
    // Each byte-write mask covers a nine-bit lane
    localparam int DBSP_LANE_W = 9;
    localparam int DBSP_BURST_LEN = 2;
    // Read pipeline: first beat leaves at half-cycle slot 4, second at slot 5
    localparam int DBSP_RD_PIPE_LEN = 4;
    localparam int DBSP_RD_BEAT0_STAGE = 2;
    localparam int DBSP_RD_BEAT1_STAGE = 3;
    // Write command buffer depth on the controller side
    localparam int DBSP_FIFO_DEPTH = 16;
    // System clock: 50 MHz, 20 ns; one period is one half of the link clock pair
    localparam int DBSP_CLOCK_PERIOD_NS = 20;
    localparam int DBSP_SLOTS_PER_CYCLE = 2;

    // Address width that matches a given data width, zero when unsupported
    function automatic int dbsp_addr_w(input int data_w);
        if (data_w == DBSP_DATA_W_WIDE) begin
            return DBSP_ADDR_W_WIDE;
        end else if (data_w == DBSP_DATA_W_NARROW) begin
            return DBSP_ADDR_W_NARROW;
        end
        return 0;
    endfunction
endpackage
`default_nettype wire

// file: inc/dbsp_link_if.sv
// Link between the memory device and its controller
`timescale 1ns/10ps
`default_nettype none
interface dbsp_link_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20
);
    localparam int MASK_W = DATA_W / 9;
    // Input clock pair, modelled as slot levels: k_true high marks a K rising slot
    logic k_true;
    logic k_comp;
    // Commands, address and write data
    logic rd_sel_n;
    logic wr_sel_n;
    logic [ADDR_W-1:0] sync_address;
    logic [DATA_W-1:0] write_data_in;
    logic [MASK_W-1:0] byte_write_mask_n;
    // Read return
    logic [DATA_W-1:0] read_data_out;
    logic echo_strobe_true;
    logic echo_strobe_comp;
    logic output_valid_flag;

    modport device (
        input k_true, k_comp, rd_sel_n, wr_sel_n, sync_address, write_data_in,
        input byte_write_mask_n,
        output read_data_out, echo_strobe_true, echo_strobe_comp, output_valid_flag
    );
    modport controller (
        output k_true, k_comp, rd_sel_n, wr_sel_n, sync_address, write_data_in,
        output byte_write_mask_n,
        input read_data_out, echo_strobe_true, echo_strobe_comp, output_valid_flag
    );
endinterface
`default_nettype wire

// file: logic/dbsp_sram_device.sv
// Memory device end: command capture, write buffer, array and read pipeline
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - K rising slot starts every operation
// - Read and write addresses alternate on shared bus
// - K slot takes read address, selects, beat0
// - K# slot takes write address, beat1 and its mask
// - Masks accompany their own data beat
// - Buffer holds beat0 until write address
// - Controller sends beat0 with command, beat1 next
// - First read beat at second K slot after command
// - Second read beat at following K# slot
// - Every burst is exactly two beats
// - Separate read and write buses, concurrent
// - 2Mx36 or 4Mx18, address sized to match
// - Echo strobe pair travels with read data
// - Both clock edges launch output beats
// - Pipelined reads, early-write data timing
// - Low read select at K starts read
// - Low write select at K starts write
// - Low mask writes lane, high keeps it
// - Valid flag marks read data, echo aligned
module dbsp_sram_device
    import dbsp_pkg::*;
#(
    parameter int DATA_W = DBSP_DATA_W_WIDE,
    parameter int ADDR_W = DBSP_ADDR_W_WIDE
) (
    // System
    input wire logic clock,
    input wire logic resetn,
    // Link
    dbsp_link_if.device link
);
    localparam int MASK_W = DATA_W / DBSP_LANE_W;
    localparam int WORDS = DBSP_BURST_LEN * (2 ** ADDR_W);

    if (ADDR_W != dbsp_addr_w(DATA_W)) begin : g_bad_size
        $error("dbsp_sram_device: unsupported data or address width");
    end

    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [MASK_W-1:0] mask_n
    );
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < MASK_W; i++) begin
            if (!mask_n[i]) begin
                res[i*DBSP_LANE_W +: DBSP_LANE_W] = new_w[i*DBSP_LANE_W +: DBSP_LANE_W];
            end
        end
        return res;
    endfunction

    logic k_slot;
    logic c_slot;
    logic rd_start;
    // Write capture from the K slot
    logic wr_go_q;
    logic [DATA_W-1:0] beat0_d_q;
    logic [MASK_W-1:0] beat0_m_q;
    // Write buffer: one whole burst waiting to reach the array
    logic pend_v_q;
    logic [ADDR_W-1:0] pend_a_q;
    logic [DATA_W-1:0] pend_d0_q;
    logic [DATA_W-1:0] pend_d1_q;
    logic [MASK_W-1:0] pend_m0_q;
    logic [MASK_W-1:0] pend_m1_q;
    logic [DATA_W-1:0] mem [WORDS];
    // Read pipeline
    logic [DBSP_RD_PIPE_LEN-1:0] rd_sr_q;
    logic [ADDR_W-1:0] ra_q [DBSP_RD_PIPE_LEN];
    logic [DATA_W-1:0] fwd0;
    logic [DATA_W-1:0] fwd1;
    logic [DATA_W-1:0] q_q;
    logic [DATA_W-1:0] q2_q;
    logic vld_q;
    logic echo_t_q;
    logic echo_c_q;

    assign k_slot = link.k_true;
    assign c_slot = link.k_comp;
    assign rd_start = k_slot && !link.rd_sel_n;

    // K slot: write select and first data beat with its masks
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_go_q <= 1'b0;
            beat0_d_q <= '0;
            beat0_m_q <= '1;
        end else if (k_slot) begin
            wr_go_q <= !link.wr_sel_n;
            beat0_d_q <= link.write_data_in;
            beat0_m_q <= link.byte_write_mask_n;
        end
    end

    // K# slot: the address of a started write arrives with the second beat.
    // The older buffered burst is retired to the array only now, so a read
    // that lands between command and retirement is served from the buffer.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pend_v_q <= 1'b0;
            pend_a_q <= '0;
            pend_d0_q <= '0;
            pend_d1_q <= '0;
            pend_m0_q <= '1;
            pend_m1_q <= '1;
        end else if (c_slot && wr_go_q) begin
            pend_v_q <= 1'b1;
            pend_a_q <= link.sync_address;
            pend_d0_q <= beat0_d_q;
            pend_d1_q <= link.write_data_in;
            pend_m0_q <= beat0_m_q;
            pend_m1_q <= link.byte_write_mask_n;
        end
    end

    // Array retirement of the buffered burst, both beats at once
    always_ff @(posedge clock) begin
        if (resetn && c_slot && wr_go_q && pend_v_q) begin
            mem[{pend_a_q, 1'b0}] <= lane_merge(mem[{pend_a_q, 1'b0}], pend_d0_q, pend_m0_q);
            mem[{pend_a_q, 1'b1}] <= lane_merge(mem[{pend_a_q, 1'b1}], pend_d1_q, pend_m1_q);
        end
    end

    // Read command and address ride a shift register one stage per half cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rd_sr_q <= '0;
            for (int i = 0; i < DBSP_RD_PIPE_LEN; i++) begin
                ra_q[i] <= '0;
            end
        end else begin
            rd_sr_q <= {rd_sr_q[DBSP_RD_PIPE_LEN-2:0], rd_start};
            ra_q[0] <= k_slot ? link.sync_address : ra_q[0];
            for (int i = 1; i < DBSP_RD_PIPE_LEN; i++) begin
                ra_q[i] <= ra_q[i-1];
            end
        end
    end

    // Both beats are looked up together; fetching beat 1 a slot later could
    // pick up a write that was issued after this read
    always_comb begin
        fwd0 = mem[{ra_q[DBSP_RD_BEAT0_STAGE], 1'b0}];
        fwd1 = mem[{ra_q[DBSP_RD_BEAT0_STAGE], 1'b1}];
        if (pend_v_q && pend_a_q == ra_q[DBSP_RD_BEAT0_STAGE]) begin
            fwd0 = lane_merge(fwd0, pend_d0_q, pend_m0_q);
            fwd1 = lane_merge(fwd1, pend_d1_q, pend_m1_q);
        end
    end

    // Output register on its own bus, free of any write traffic
    always_ff @(posedge clock) begin
        if (!resetn) begin
            q_q <= '0;
            q2_q <= '0;
            vld_q <= 1'b0;
        end else if (rd_sr_q[DBSP_RD_BEAT0_STAGE]) begin
            q_q <= fwd0;
            q2_q <= fwd1;
            vld_q <= 1'b1;
        end else if (rd_sr_q[DBSP_RD_BEAT1_STAGE]) begin
            q_q <= q2_q;
            vld_q <= 1'b1;
        end else begin
            vld_q <= 1'b0;
        end
    end

    // Echo strobes are re-timed by the same edge as the data so they stay aligned
    always_ff @(posedge clock) begin
        if (!resetn) begin
            echo_t_q <= 1'b0;
            echo_c_q <= 1'b1;
        end else begin
            echo_t_q <= k_slot;
            echo_c_q <= c_slot;
        end
    end

    assign link.read_data_out = q_q;
    assign link.output_valid_flag = vld_q;
    assign link.echo_strobe_true = echo_t_q;
    assign link.echo_strobe_comp = echo_c_q;
endmodule // dbsp_sram_device
`default_nettype wire

// file: logic/dbsp_mem_ctrl.sv
// Memory controller end: write command FIFO, clock pair, command issue, read capture
`timescale 1ns/10ps
`default_nettype none
module dbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // System
    input wire logic clock,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    if (DEPTH < 2 || (2 ** PTR_W) != DEPTH) begin : g_bad_depth
        $error("dbsp_fifo: depth must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wp_q;
    logic [PTR_W-1:0] rp_q;
    logic [PTR_W:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != (PTR_W+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = store[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            store[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= push ? wp_q + 1'b1 : wp_q;
            rp_q <= pop ? rp_q + 1'b1 : rp_q;
            cnt_q <= cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule // dbsp_fifo

module dbsp_mem_ctrl
    import dbsp_pkg::*;
#(
    parameter int DATA_W = DBSP_DATA_W_WIDE,
    parameter int ADDR_W = DBSP_ADDR_W_WIDE,
    parameter int FIFO_DEPTH = DBSP_FIFO_DEPTH
) (
    // System
    input wire logic clock,
    input wire logic resetn,
    // Write requests
    input wire logic wr_req_valid,
    output logic wr_req_ready,
    input wire logic [ADDR_W-1:0] wr_req_addr,
    input wire logic [DATA_W-1:0] wr_req_data0,
    input wire logic [DATA_W-1:0] wr_req_data1,
    input wire logic [DATA_W/DBSP_LANE_W-1:0] wr_req_mask_n0,
    input wire logic [DATA_W/DBSP_LANE_W-1:0] wr_req_mask_n1,
    // Read requests
    input wire logic rd_req_valid,
    output logic rd_req_ready,
    input wire logic [ADDR_W-1:0] rd_req_addr,
    // Read responses
    output logic rd_rsp_valid,
    output logic [DATA_W-1:0] rd_rsp_data0,
    output logic [DATA_W-1:0] rd_rsp_data1,
    // Link
    dbsp_link_if.controller link
);
    localparam int MASK_W = DATA_W / DBSP_LANE_W;
    localparam int ENT_W = ADDR_W + 2 * DATA_W + 2 * MASK_W;

    if (ADDR_W != dbsp_addr_w(DATA_W)) begin : g_bad_size
        $error("dbsp_mem_ctrl: unsupported data or address width");
    end

    logic phase_q;
    logic f_valid;
    logic [ENT_W-1:0] f_data;
    logic wr_pop;
    logic rd_take;
    logic [ADDR_W-1:0] h_addr_q;
    logic [DATA_W-1:0] h_d1_q;
    logic [MASK_W-1:0] h_m1_q;
    logic rd_sel_n_q;
    logic wr_sel_n_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic [MASK_W-1:0] mask_q;
    logic rx_beat_q;
    logic rsp_v_q;
    logic [DATA_W-1:0] rsp_d0_q;
    logic [DATA_W-1:0] rsp_d1_q;

    // Commands go out only ahead of a K slot, so the FIFO drains at most every
    // other clock and a steady write stream really backs up into wr_req_ready
    dbsp_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_valid(wr_req_valid),
        .in_ready(wr_req_ready),
        .in_data({wr_req_addr, wr_req_data0, wr_req_data1, wr_req_mask_n0, wr_req_mask_n1}),
        .out_valid(f_valid),
        .out_ready(!phase_q),
        .out_data(f_data)
    );

    assign wr_pop = f_valid && !phase_q;
    assign rd_req_ready = !phase_q;
    assign rd_take = rd_req_valid && !phase_q;

    // Clock pair divided from the system clock, one half per clock period
    always_ff @(posedge clock) begin
        if (!resetn) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= !phase_q;
        end
    end

    // Drive the K slot with read address, selects and beat 0, then the K# slot
    // with write address and beat 1 of the same burst
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rd_sel_n_q <= 1'b1;
            wr_sel_n_q <= 1'b1;
            addr_q <= '0;
            data_q <= '0;
            mask_q <= '1;
            h_addr_q <= '0;
            h_d1_q <= '0;
            h_m1_q <= '1;
        end else if (!phase_q) begin
            rd_sel_n_q <= !rd_take;
            wr_sel_n_q <= !wr_pop;
            addr_q <= rd_take ? rd_req_addr : '0;
            data_q <= f_data[DATA_W+2*MASK_W +: DATA_W];
            mask_q <= wr_pop ? f_data[MASK_W +: MASK_W] : '1;
            h_addr_q <= f_data[2*DATA_W+2*MASK_W +: ADDR_W];
            h_d1_q <= f_data[2*MASK_W +: DATA_W];
            h_m1_q <= wr_pop ? f_data[0 +: MASK_W] : '1;
        end else begin
            rd_sel_n_q <= 1'b1;
            wr_sel_n_q <= 1'b1;
            addr_q <= h_addr_q;
            data_q <= h_d1_q;
            mask_q <= h_m1_q;
        end
    end

    // Pair the two returned beats by the valid flag
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rx_beat_q <= 1'b0;
            rsp_v_q <= 1'b0;
            rsp_d0_q <= '0;
            rsp_d1_q <= '0;
        end else begin
            rsp_v_q <= link.output_valid_flag && rx_beat_q;
            if (link.output_valid_flag) begin
                rx_beat_q <= !rx_beat_q;
                if (rx_beat_q) begin
                    rsp_d1_q <= link.read_data_out;
                end else begin
                    rsp_d0_q <= link.read_data_out;
                end
            end
        end
    end

    assign link.k_true = phase_q;
    assign link.k_comp = !phase_q;
    assign link.rd_sel_n = rd_sel_n_q;
    assign link.wr_sel_n = wr_sel_n_q;
    assign link.sync_address = addr_q;
    assign link.write_data_in = data_q;
    assign link.byte_write_mask_n = mask_q;
    assign rd_rsp_valid = rsp_v_q;
    assign rd_rsp_data0 = rsp_d0_q;
    assign rd_rsp_data1 = rsp_d1_q;
endmodule // dbsp_mem_ctrl
`default_nettype wire

// file: tb/dbsp_link_properties.sv
// Concurrent checks on the link between controller and memory device
`timescale 1ns/10ps
`default_nettype none
module dbsp_link_properties #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20
) (
    // System
    input wire logic clock,
    input wire logic resetn,
    // Link
    input wire logic k_true,
    input wire logic k_comp,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [ADDR_W-1:0] sync_address,
    input wire logic [DATA_W-1:0] write_data_in,
    input wire logic [DATA_W/9-1:0] byte_write_mask_n,
    input wire logic [DATA_W-1:0] read_data_out,
    input wire logic echo_strobe_true,
    input wire logic echo_strobe_comp,
    input wire logic output_valid_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic rd_cmd;
    assign rd_cmd = k_true & ~rd_sel_n;
    a_pair_opposite: assert property (k_comp == ~k_true)
        else $error("clock pair not complementary");
    a_k_alternate: assert property ($past(resetn) |-> k_true != $past(k_true))
        else $error("K slots do not alternate");
    a_read_first_beat: assert property (rd_cmd |-> ##4 output_valid_flag)
        else $error("first read beat late");
    a_read_second_beat: assert property (rd_cmd |-> ##5 output_valid_flag)
        else $error("second read beat late");
    a_valid_has_cause: assert property (output_valid_flag |-> $past(rd_cmd, 4) || $past(rd_cmd, 5))
        else $error("valid without a read");
    a_valid_two_beats: assert property ($rose(output_valid_flag) |-> ##1 output_valid_flag)
        else $error("burst shorter than two beats");
    a_echo_runs: assert property ($past(resetn) && $past(resetn, 2)
        |-> echo_strobe_true != $past(echo_strobe_true))
        else $error("echo strobe stopped");
    a_echo_opposite: assert property (echo_strobe_true != echo_strobe_comp)
        else $error("echo pair not complementary");
    a_data_idle_hold: assert property (!output_valid_flag |-> $stable(read_data_out))
        else $error("read data moved without valid");
    a_write_k_only: assert property (k_comp |-> wr_sel_n)
        else $error("write select in K# slot");
    c_read: cover property (rd_cmd && !wr_sel_n);
    c_back_to_back: cover property (output_valid_flag [*4]);
    c_write: cover property (k_true && !wr_sel_n && byte_write_mask_n != '1);
endmodule // dbsp_link_properties
`default_nettype wire

// file: tb/ddr_burst2_sram_port_tb_top.sv
// Self-checking bench: controller and memory device joined over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ddr_burst2_sram_port_tb_top;
    import dbsp_pkg::*;
    localparam int DW = DBSP_DATA_W_WIDE;
    localparam int AW = DBSP_ADDR_W_WIDE;
    localparam int MW = DW / DBSP_LANE_W;
    // One clock to launch, two link cycles in the device, one to capture
    localparam int RSP_LAT = 2 + 2 * DBSP_SLOTS_PER_CYCLE;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic wr_req_valid = 1'b0;
    logic wr_req_ready;
    logic [AW-1:0] wr_req_addr = '0;
    logic [DW-1:0] wr_req_data0 = '0;
    logic [DW-1:0] wr_req_data1 = '0;
    logic [MW-1:0] wr_req_mask_n0 = '1;
    logic [MW-1:0] wr_req_mask_n1 = '1;
    logic rd_req_valid = 1'b0;
    logic rd_req_ready;
    logic [AW-1:0] rd_req_addr = '0;
    logic rd_rsp_valid;
    logic [DW-1:0] rd_rsp_data0;
    logic [DW-1:0] rd_rsp_data1;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [DW-1:0] mem_q [logic [AW:0]];

    always #(DBSP_CLOCK_PERIOD_NS / 2) clock = ~clock;

    dbsp_link_if #(.DATA_W(DW), .ADDR_W(AW)) dbsp_link_if_inst ();
    dbsp_mem_ctrl dbsp_mem_ctrl_inst (.clock(clock), .resetn(resetn),
        .wr_req_valid(wr_req_valid), .wr_req_ready(wr_req_ready), .wr_req_addr(wr_req_addr),
        .wr_req_data0(wr_req_data0), .wr_req_data1(wr_req_data1),
        .wr_req_mask_n0(wr_req_mask_n0), .wr_req_mask_n1(wr_req_mask_n1),
        .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr),
        .rd_rsp_valid(rd_rsp_valid), .rd_rsp_data0(rd_rsp_data0),
        .rd_rsp_data1(rd_rsp_data1), .link(dbsp_link_if_inst));
    dbsp_sram_device dbsp_sram_device_inst (.clock(clock), .resetn(resetn),
        .link(dbsp_link_if_inst));
    dbsp_link_properties #(.DATA_W(DW), .ADDR_W(AW)) dbsp_link_properties_inst (
        .clock(clock), .resetn(resetn), .k_true(dbsp_link_if_inst.k_true),
        .k_comp(dbsp_link_if_inst.k_comp), .rd_sel_n(dbsp_link_if_inst.rd_sel_n),
        .wr_sel_n(dbsp_link_if_inst.wr_sel_n), .sync_address(dbsp_link_if_inst.sync_address),
        .write_data_in(dbsp_link_if_inst.write_data_in),
        .byte_write_mask_n(dbsp_link_if_inst.byte_write_mask_n),
        .read_data_out(dbsp_link_if_inst.read_data_out),
        .echo_strobe_true(dbsp_link_if_inst.echo_strobe_true),
        .echo_strobe_comp(dbsp_link_if_inst.echo_strobe_comp),
        .output_valid_flag(dbsp_link_if_inst.output_valid_flag));

    // Shadow of the array; a low mask bit replaces its nine-bit lane
    task automatic note(input logic [AW:0] k, input logic [DW-1:0] d, input logic [MW-1:0] m);
        logic [DW-1:0] w;
        w = mem_q.exists(k) ? mem_q[k] : 'x;
        for (int i = 0; i < MW; i++) begin
            if (!m[i]) begin
                w[i*DBSP_LANE_W +: DBSP_LANE_W] = d[i*DBSP_LANE_W +: DBSP_LANE_W];
            end
        end
        mem_q[k] = w;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0,
                      input logic [DW-1:0] d1, input logic [MW-1:0] m0, input logic [MW-1:0] m1);
        @(negedge clock);
        wr_req_valid = 1'b1;
        wr_req_addr = a;
        wr_req_data0 = d0;
        wr_req_data1 = d1;
        wr_req_mask_n0 = m0;
        wr_req_mask_n1 = m1;
        while (!wr_req_ready) @(negedge clock);
        note({a, 1'b0}, d0, m0);
        note({a, 1'b1}, d1, m1);
        @(negedge clock);
        wr_req_valid = 1'b0;
    endtask

    task automatic rsp_check(input logic [AW-1:0] a, input int n);
        while (!rd_rsp_valid && n < 40) begin
            @(negedge clock);
            n++;
        end
        `CHK(rd_rsp_data0, mem_q[{a, 1'b0}])
        `CHK(rd_rsp_data1, mem_q[{a, 1'b1}])
    endtask

    task automatic rd_check(input logic [AW-1:0] a);
        int n;
        @(negedge clock);
        rd_req_valid = 1'b1;
        rd_req_addr = a;
        while (!rd_req_ready) @(negedge clock);
        @(negedge clock);
        rd_req_valid = 1'b0;
        // Half a clock after the taking edge, so no edge has been counted yet
        n = 0;
        while (!rd_rsp_valid && n < 40) begin
            @(negedge clock);
            n++;
        end
        `CHK(n, RSP_LAT)
        rsp_check(a, n);
        @(negedge clock);
        `CHK(rd_rsp_valid, 1'b0)
    endtask

    task automatic s_basic();
        wr(20'h00005, {4{9'h0a5}}, {4{9'h15a}}, 4'h0, 4'h0);
        rd_check(20'h00005);
        wr(20'h00006, {4{9'h0c3}}, {4{9'h13c}}, 4'h0, 4'h0);
        rd_check(20'h00005);
        rd_check(20'h00006);
    endtask

    // Each beat opens a different lane, so a mask tied to the wrong beat shows
    task automatic s_masks();
        logic [8:0] b;
        for (int i = 0; i < MW; i++) begin
            b = 9'h101 + 9'(i);
            wr(20'h00005, {MW{b}}, {MW{~b}}, ~(4'h1 << i), ~(4'h1 << ((i + 1) % MW)));
            rd_check(20'h00005);
        end
        wr(20'h00006, {4{9'h0ff}}, {4{9'h011}}, 4'h5, 4'ha);
        rd_check(20'h00005);
    endtask

    task automatic s_concurrent();
        fork
            wr(20'h00007, {4{9'h1e1}}, {4{9'h01e}}, 4'h0, 4'h0);
            rd_check(20'h00005);
        join
        rd_check(20'h00007);
    endtask

    task automatic s_b2b();
        fork
            begin
                @(negedge clock);
                rd_req_valid = 1'b1;
                for (int k = 5; k < 8; k++) begin
                    rd_req_addr = AW'(k);
                    while (!rd_req_ready) @(negedge clock);
                    @(negedge clock);
                end
                rd_req_valid = 1'b0;
            end
            for (int k = 5; k < 8; k++) begin
                @(negedge clock);
                rsp_check(AW'(k), 0);
            end
        join
    endtask

    // Valid held high at full rate outruns the two-clock drain until the FIFO refuses
    task automatic s_fill();
        int taken;
        logic full_seen;
        taken = 0;
        full_seen = 1'b0;
        @(negedge clock);
        wr_req_valid = 1'b1;
        wr_req_mask_n0 = '0;
        wr_req_mask_n1 = '0;
        while (taken < 40) begin
            wr_req_addr = AW'(100 + taken);
            wr_req_data0 = DW'(36'h3_0000_0000 + taken);
            wr_req_data1 = DW'(36'h0_0f00_0000 + taken);
            if (wr_req_ready) begin
                note({wr_req_addr, 1'b0}, wr_req_data0, '0);
                note({wr_req_addr, 1'b1}, wr_req_data1, '0);
                taken++;
            end else begin
                full_seen = 1'b1;
            end
            @(negedge clock);
        end
        wr_req_valid = 1'b0;
        `CHK(full_seen, 1'b1)
        repeat (2 * DBSP_FIFO_DEPTH + 4) @(negedge clock);
        rd_check(20'd100);
        rd_check(20'd139);
    endtask

    task automatic test_done();
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        s_basic();
        s_masks();
        s_concurrent();
        s_b2b();
        s_fill();
        test_done();
    end
endmodule // ddr_burst2_sram_port_tb_top
`default_nettype wire
